// File: tmz_pkg.sv
// package for the 8-bit timer: codes, reset values, structs
// assumes nothing of its surroundings
package tmz_pkg;

    // ------------------------------------------------------------------
    // counter constants
    // ------------------------------------------------------------------
    localparam logic [7:0] CNT_BOTTOM   = 8'h00;
    localparam logic [7:0] CNT_MAX      = 8'hFF;
    localparam logic [7:0] CNT_RESET    = 8'h00;
    localparam logic [7:0] CMP_RESET    = 8'h00;

    // ------------------------------------------------------------------
    // waveform mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] WGM_NORMAL   = 3'h0;
    localparam logic [2:0] WGM_PC_MAX   = 3'h1;
    localparam logic [2:0] WGM_CTC      = 3'h2;
    localparam logic [2:0] WGM_FAST_MAX = 3'h3;
    localparam logic [2:0] WGM_PC_OCRA  = 3'h5;
    localparam logic [2:0] WGM_FAST_OCRA = 3'h7;

    // ------------------------------------------------------------------
    // clock select codes
    // ------------------------------------------------------------------
    localparam logic [2:0] CS_STOP      = 3'h0;
    localparam logic [2:0] CS_DIV1      = 3'h1;
    localparam logic [2:0] CS_DIV8      = 3'h2;
    localparam logic [2:0] CS_DIV64     = 3'h3;
    localparam logic [2:0] CS_DIV256    = 3'h4;
    localparam logic [2:0] CS_DIV1024   = 3'h5;
    localparam logic [2:0] CS_EXT_FALL  = 3'h6;
    localparam logic [2:0] CS_EXT_RISE  = 3'h7;

    // prescaler taps: division factor minus one
    localparam logic [9:0] PS_MASK8     = 10'h007;
    localparam logic [9:0] PS_MASK64    = 10'h03F;
    localparam logic [9:0] PS_MASK256   = 10'h0FF;
    localparam logic [9:0] PS_MASK1024  = 10'h3FF;

    // compare output modes
    localparam logic [1:0] COM_NONE     = 2'h0;
    localparam logic [1:0] COM_TOGGLE   = 2'h1;
    localparam logic [1:0] COM_CLEAR    = 2'h2;
    localparam logic [1:0] COM_SET      = 2'h3;

    // ------------------------------------------------------------------
    // grouped control and flags
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] waveform_mode_field;
        logic [2:0] clock_select_field;
        logic [1:0] compare_output_mode_a;
        logic [1:0] compare_output_mode_b;
    } tmz_ctrl_s;

    typedef struct packed {
        logic compare_flag_b;
        logic compare_flag_a;
        logic overflow_flag;
    } tmz_flags_s;

endpackage

// File: tmz_cmp_chan.sv
// one compare channel: buffer, active value, flag, output
// assumes tick and update strobes come from the parent
`timescale 1ns/10ps
module tmz_cmp_chan (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // software access
    input  wire logic       cmp_we,
    input  wire logic [7:0] cmp_wdata,
    input  wire logic       force_compare_bit,
    input  wire logic       flag_clr,
    // counter context
    input  wire logic [7:0] timer_count,
    input  wire logic       tick,
    input  wire logic       block_match,
    input  wire logic       pwm_mode,
    input  wire logic       update_strobe,
    input  wire logic       inv_level,
    input  wire logic [1:0] compare_output_mode,
    // results
    output logic [7:0]      compare_value,
    output logic [7:0]      compare_active,
    output logic            match,
    output logic            compare_flag_x,
    output logic            compare_out_x
);

    logic [7:0] buf_q;
    logic [7:0] act_q;
    logic       flag_q;
    logic       out_q;
    logic       match_evt;

    // compare against the active value
    assign match = (timer_count == act_q);
    // a match acts on a tick unless a counter write blocks it
    assign match_evt = tick & match & ~block_match;

    // buffer register that software sees
    always_ff @(posedge mclk) begin
        if (rst) begin
            buf_q <= tmz_pkg::CMP_RESET;
        end else if (cmp_we) begin
            buf_q <= cmp_wdata;
        end
    end

    // active value: direct outside pwm, copied at top in pwm
    always_ff @(posedge mclk) begin
        if (rst) begin
            act_q <= tmz_pkg::CMP_RESET;
        end else if (!pwm_mode) begin
            if (cmp_we) begin
                act_q <= cmp_wdata;
            end
        end else if (update_strobe) begin
            act_q <= buf_q;
        end
    end

    // flag: set beats clear; a force never sets it
    always_ff @(posedge mclk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (match_evt) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    // output state from match or force
    always_ff @(posedge mclk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (pwm_mode) begin
            if (match_evt && compare_output_mode[1]) begin
                out_q <= inv_level ^ compare_output_mode[0];
            end
        end else if (match_evt || force_compare_bit) begin
            case (compare_output_mode)
                tmz_pkg::COM_TOGGLE: out_q <= ~out_q;
                tmz_pkg::COM_CLEAR:  out_q <= 1'b0;
                tmz_pkg::COM_SET:    out_q <= 1'b1;
                default:             out_q <= out_q;
            endcase
        end
    end

    assign compare_value  = buf_q;
    assign compare_active = act_q;
    assign compare_flag_x = flag_q;
    assign compare_out_x  = out_q;

endmodule

// File: tmz_timer.sv
// 8-bit timer/counter, two compare channels, flags and masks
// assumes strobes are one-cycle pulses on mclk
`timescale 1ns/10ps
module tmz_timer (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // configuration
    input  tmz_pkg::tmz_ctrl_s      ctrl,
    input  wire logic               timer_power_down_bit,
    input  wire logic [2:0]         timer_mask_reg,
    // counter access
    input  wire logic               timer_count_we,
    input  wire logic [7:0]         timer_count_wdata,
    // compare access
    input  wire logic               compare_a_we,
    input  wire logic               compare_b_we,
    input  wire logic [7:0]         compare_wdata,
    input  wire logic [1:0]         force_compare_bit,
    // flag clearing: write-one mask and interrupt service acknowledges
    input  wire logic               flag_we,
    input  wire logic [2:0]         flag_wdata,
    input  wire logic [2:0]         irq_ack,
    // external count pin
    input  wire logic               ext_count_pin,
    // status and outputs
    output logic [7:0]              timer_count,
    output logic [7:0]              compare_value_a,
    output logic [7:0]              compare_value_b,
    output tmz_pkg::tmz_flags_s     timer_flag_reg,
    output logic [2:0]              irq_req,
    output logic                    bottom,
    output logic                    compare_out_a,
    output logic                    compare_out_b
);

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    logic [2:0] wgm;
    logic       pwm_mode;
    logic       phase_correct;
    logic       top_is_ocra;
    logic       ctc_mode;
    logic [7:0] top_value;
    logic [7:0] cmp_act_a;
    logic [7:0] cmp_act_b;

    assign wgm           = ctrl.waveform_mode_field;
    assign ctc_mode      = (wgm == tmz_pkg::WGM_CTC);
    assign pwm_mode      = (wgm == tmz_pkg::WGM_PC_MAX) || (wgm == tmz_pkg::WGM_FAST_MAX)
                        || (wgm == tmz_pkg::WGM_PC_OCRA) || (wgm == tmz_pkg::WGM_FAST_OCRA);
    assign phase_correct = (wgm == tmz_pkg::WGM_PC_MAX) || (wgm == tmz_pkg::WGM_PC_OCRA);
    assign top_is_ocra   = ctc_mode || (wgm == tmz_pkg::WGM_PC_OCRA)
                        || (wgm == tmz_pkg::WGM_FAST_OCRA);
    // top follows the active compare A, not its buffer
    assign top_value     = top_is_ocra ? cmp_act_a : tmz_pkg::CNT_MAX;

    // ------------------------------------------------------------------
    // prescaler and tick source
    // ------------------------------------------------------------------
    logic [9:0] ps_q;
    logic       ext_q;
    logic       ext_prev_q;
    logic       tick;
    logic       run;

    // power-down high gates the prescaler and the tick, not writes
    assign run = ~timer_power_down_bit;

    // prescaler runs only while the block is powered
    always_ff @(posedge mclk) begin
        if (rst) begin
            ps_q <= 10'h000;
        end else if (run) begin
            ps_q <= ps_q + 10'h001;
        end
    end

    // edge detect; pin taken as synchronous
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_q      <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_q      <= ext_count_pin;
            ext_prev_q <= ext_q;
        end
    end

    // tick select: source and edge from the clock select field
    always_comb begin
        case (ctrl.clock_select_field)
            tmz_pkg::CS_STOP:     tick = 1'b0;
            tmz_pkg::CS_DIV1:     tick = 1'b1;
            tmz_pkg::CS_DIV8:     tick = ((ps_q & tmz_pkg::PS_MASK8) == tmz_pkg::PS_MASK8);
            tmz_pkg::CS_DIV64:    tick = ((ps_q & tmz_pkg::PS_MASK64) == tmz_pkg::PS_MASK64);
            tmz_pkg::CS_DIV256:   tick = ((ps_q & tmz_pkg::PS_MASK256) == tmz_pkg::PS_MASK256);
            tmz_pkg::CS_DIV1024:  tick = (ps_q == tmz_pkg::PS_MASK1024);
            tmz_pkg::CS_EXT_FALL: tick = ext_prev_q & ~ext_q;
            tmz_pkg::CS_EXT_RISE: tick = ~ext_prev_q & ext_q;
            default:              tick = 1'b0;
        endcase
        tick = tick & run;
    end

    // ------------------------------------------------------------------
    // counter unit
    // ------------------------------------------------------------------
    logic [7:0] cnt_q;
    logic       down_q;
    logic       at_top;
    logic       block_q;
    logic       ovf_evt;
    logic       update_strobe;

    assign at_top = (cnt_q == top_value);
    assign bottom = (cnt_q == tmz_pkg::CNT_BOTTOM);

    // counter: write beats clear beats count
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= tmz_pkg::CNT_RESET;
        end else if (timer_count_we) begin
            cnt_q <= timer_count_wdata;
        end else if (tick) begin
            if (phase_correct) begin
                if (down_q) begin
                    cnt_q <= bottom ? cnt_q + 8'h01 : cnt_q - 8'h01;
                end else begin
                    cnt_q <= at_top ? cnt_q - 8'h01 : cnt_q + 8'h01;
                end
            end else if (at_top && wgm != tmz_pkg::WGM_NORMAL) begin
                cnt_q <= tmz_pkg::CNT_BOTTOM;
            end else begin
                cnt_q <= cnt_q + 8'h01; // wraps 0xFF to 0x00
            end
        end
    end

    // direction matters in phase-correct modes only
    always_ff @(posedge mclk) begin
        if (rst) begin
            down_q <= 1'b0;
        end else if (!phase_correct) begin
            down_q <= 1'b0;
        end else if (tick && !timer_count_we) begin
            if (at_top) begin
                down_q <= 1'b1;
            end else if (bottom) begin
                down_q <= 1'b0;
            end
        end
    end

    // a counter write blocks the match on the next tick so a count equal
    // to the compare value can be written without a spurious flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            block_q <= 1'b0;
        end else if (timer_count_we) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // overflow at max, or at the bottom turn in phase-correct
    assign ovf_evt = tick & ~timer_count_we &
                     (phase_correct ? (bottom & down_q)
                                    : (cnt_q == tmz_pkg::CNT_MAX));

    // buffered compare update at top in every pwm mode
    assign update_strobe = tick & ~timer_count_we & at_top;

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    logic ovf_q;
    logic ovf_clr;
    logic [1:0] cmp_clr;
    logic flag_a;
    logic flag_b;

    assign ovf_clr    = (flag_we & flag_wdata[0]) | irq_ack[0];
    assign cmp_clr[0] = (flag_we & flag_wdata[1]) | irq_ack[1];
    assign cmp_clr[1] = (flag_we & flag_wdata[2]) | irq_ack[2];

    // overflow flag; a new overflow beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_q <= 1'b1;
        end else if (ovf_clr) begin
            ovf_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // compare channels
    // ------------------------------------------------------------------
    logic inv_level;

    // phase-correct: sense flips with direction
    assign inv_level = phase_correct & down_q;

    tmz_cmp_chan u_cmp_a (
        .mclk                (mclk),
        .rst                 (rst),
        .cmp_we              (compare_a_we),
        .cmp_wdata           (compare_wdata),
        .force_compare_bit   (force_compare_bit[0]),
        .flag_clr            (cmp_clr[0]),
        .timer_count         (cnt_q),
        .tick                (tick & ~timer_count_we),
        .block_match         (block_q),
        .pwm_mode            (pwm_mode),
        .update_strobe       (update_strobe),
        .inv_level           (inv_level),
        .compare_output_mode (ctrl.compare_output_mode_a),
        .compare_value       (compare_value_a),
        .compare_active      (cmp_act_a),
        .match               (),
        .compare_flag_x      (flag_a),
        .compare_out_x       (compare_out_a)
    );

    tmz_cmp_chan u_cmp_b (
        .mclk                (mclk),
        .rst                 (rst),
        .cmp_we              (compare_b_we),
        .cmp_wdata           (compare_wdata),
        .force_compare_bit   (force_compare_bit[1]),
        .flag_clr            (cmp_clr[1]),
        .timer_count         (cnt_q),
        .tick                (tick & ~timer_count_we),
        .block_match         (block_q),
        .pwm_mode            (pwm_mode),
        .update_strobe       (update_strobe),
        .inv_level           (inv_level),
        .compare_output_mode (ctrl.compare_output_mode_b),
        .compare_value       (compare_value_b),
        .compare_active      (cmp_act_b),
        .match               (),
        .compare_flag_x      (flag_b),
        .compare_out_x       (compare_out_b)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // masks gate each request alone
    assign timer_flag_reg.overflow_flag  = ovf_q;
    assign timer_flag_reg.compare_flag_a = flag_a;
    assign timer_flag_reg.compare_flag_b = flag_b;
    assign irq_req[0] = ovf_q  & timer_mask_reg[0];
    assign irq_req[1] = flag_a & timer_mask_reg[1];
    assign irq_req[2] = flag_b & timer_mask_reg[2];
    assign timer_count = cnt_q;

endmodule

// File: tmz_timer_sva.sv
// checker for the 8-bit timer: counter, flag and mask relations
// assumes a bind to tmz_timer; sees its ports only
`timescale 1ns/10ps
module tmz_timer_chk (
    // clock and reset
    input logic                mclk,
    input logic                rst,
    // configuration
    input tmz_pkg::tmz_ctrl_s  ctrl,
    input logic                timer_power_down_bit,
    input logic [2:0]          timer_mask_reg,
    // software access
    input logic                timer_count_we,
    input logic [7:0]          timer_count_wdata,
    input logic                compare_a_we,
    input logic [7:0]          compare_wdata,
    input logic [1:0]          force_compare_bit,
    input logic                flag_we,
    input logic [2:0]          flag_wdata,
    input logic [2:0]          irq_ack,
    // results
    input logic [7:0]          timer_count,
    input logic [7:0]          compare_value_a,
    input tmz_pkg::tmz_flags_s timer_flag_reg,
    input logic [2:0]          irq_req,
    input logic                bottom
);
    // ------------------------------------------------------------------
    // helper terms
    // ------------------------------------------------------------------
    logic [2:0] flg;
    logic       idle;
    logic       run1;

    // run1: one tick a cycle in normal mode
    assign flg  = timer_flag_reg;
    assign idle = ctrl.clock_select_field == tmz_pkg::CS_STOP;
    assign run1 = ctrl.clock_select_field == tmz_pkg::CS_DIV1 && !timer_power_down_bit &&
                  ctrl.waveform_mode_field == tmz_pkg::WGM_NORMAL;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_irq_masked: assert property (irq_req == (flg & timer_mask_reg))
        else $error("irq not flag and mask");
    chk_bottom_zero: assert property (bottom == (timer_count == tmz_pkg::CNT_BOTTOM))
        else $error("bottom wrong");
    chk_stop_hold: assert property (idle && $past(idle) && !timer_count_we |=> $stable(timer_count))
        else $error("count moved when stopped");
    chk_pwrdn_hold: assert property (timer_power_down_bit && $past(timer_power_down_bit)
        && !timer_count_we |=> $stable(timer_count)) else $error("count moved in power-down");
    chk_write_wins: assert property (timer_count_we |=> timer_count == $past(timer_count_wdata))
        else $error("counter write lost");
    chk_norm_inc: assert property (run1 && $past(run1) && !timer_count_we
        |=> timer_count == $past(timer_count) + 8'h01) else $error("normal count not by one");
    chk_ovf_wrap: assert property (run1 && $past(run1) && !timer_count_we &&
        timer_count == tmz_pkg::CNT_MAX |=> timer_flag_reg.overflow_flag && bottom)
        else $error("no overflow on wrap");
    chk_flag_w1c: assert property (flag_we && idle && irq_ack == 3'h0
        |=> flg == ($past(flg) & ~$past(flag_wdata))) else $error("bad flag write");
    chk_ack_clear: assert property (|irq_ack && idle && !flag_we
        |=> (flg & $past(irq_ack)) == 3'h0) else $error("ack did not clear");
    chk_force_quiet: assert property (|force_compare_bit && idle && !flag_we && irq_ack == 3'h0
        && !timer_count_we |=> flg == $past(flg) ##0 $stable(timer_count))
        else $error("force touched flags");
    chk_match_flag: assert property (run1 && $past(run1) && !timer_count_we &&
        !$past(timer_count_we) && timer_count == compare_value_a |=> timer_flag_reg.compare_flag_a)
        else $error("no match flag");
    chk_cmp_write: assert property (compare_a_we |=> compare_value_a == $past(compare_wdata))
        else $error("compare write lost");

    // main scenarios reached
    cov_overflow: cover property ($rose(timer_flag_reg.overflow_flag));
    cov_match: cover property ($rose(timer_flag_reg.compare_flag_b));
    cov_force: cover property (|force_compare_bit && idle);
endmodule

// File: tmz_tb.sv
// bench for the 8-bit timer: drivers queue notes, a monitor compares
// assumes the package and design compile first; 50 MHz clock
`timescale 1ns/10ps
module tb;
    typedef struct {
        int         kind;
        int         due;
        logic [7:0] lo;
        logic [7:0] hi;
    } tmz_note_s;
    localparam int K_CNT = 0, K_CVA = 1, K_CVB = 2, K_FLG = 3, K_IRQ = 4, K_OUT = 5, K_BOT = 6;
    localparam int S_CNT = 0, S_CA = 1, S_CB = 2, S_FLG = 3, S_ACK = 4, S_FRC = 5;
    localparam int FAC[5] = '{1, 8, 64, 256, 1024};
    localparam logic [1:0] COM_SEQ[5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
    localparam logic [2:0] OUT_EXP[5] = '{3'h3, 3'h0, 3'h3, 3'h3, 3'h0};

    logic                mclk, rst, timer_power_down_bit, timer_count_we, compare_a_we;
    logic                compare_b_we, flag_we, ext_count_pin, bottom, compare_out_a, compare_out_b;
    logic [1:0]          force_compare_bit;
    logic [2:0]          timer_mask_reg, flag_wdata, irq_ack, irq_req;
    logic [7:0]          timer_count_wdata, compare_wdata, timer_count, compare_value_a;
    logic [7:0]          compare_value_b;
    logic [31:0]         r;
    tmz_pkg::tmz_ctrl_s  ctrl;
    tmz_pkg::tmz_flags_s timer_flag_reg;
    int                  cyc, t0, fails, comparisons, seed;
    tmz_note_s           q[$];

    tmz_timer DUT (.mclk, .rst, .ctrl, .timer_power_down_bit, .timer_mask_reg, .timer_count_we,
        .timer_count_wdata, .compare_a_we, .compare_b_we, .compare_wdata, .force_compare_bit,
        .flag_we, .flag_wdata, .irq_ack, .ext_count_pin, .timer_count, .compare_value_a,
        .compare_value_b, .timer_flag_reg, .irq_req, .bottom, .compare_out_a, .compare_out_b);

    // ------------------------------------------------------------------
    // clock, notes and comparisons
    // ------------------------------------------------------------------
    always #10 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    // due counts edges after the edge that makes the last drive; edge 1 is the one that takes it
    task automatic note(int kind, logic [7:0] lo, int d, int hi = -1);
        tmz_note_s e;
        int        i;
        e = '{kind, t0 + 1 + d, lo, (hi < 0) ? lo : 8'(hi)};
        i = 0;
        while (i < q.size() && q[i].due <= e.due) i++;
        q.insert(i, e);
    endtask

    task automatic cmp_byte(logic [7:0] a, logic [7:0] lo, logic [7:0] hi);
        comparisons++;
        if ($isunknown(a) || a < lo || a > hi) begin
            fails++;
            $display("MISMATCH t=%0t byte %h expected %h..%h", $time, a, lo, hi);
        end
    endtask

    task automatic cmp_bits(logic [2:0] a, logic [2:0] e);
        comparisons++;
        if (a !== e) begin
            fails++;
            $display("MISMATCH t=%0t bits %b expected %b", $time, a, e);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // monitor looks between edges; a hang ends in the same report
    always @(negedge mclk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            case (q[0].kind)
                K_CNT: cmp_byte(timer_count, q[0].lo, q[0].hi);
                K_CVA: cmp_byte(compare_value_a, q[0].lo, q[0].hi);
                K_CVB: cmp_byte(compare_value_b, q[0].lo, q[0].hi);
                K_FLG: cmp_bits(timer_flag_reg, q[0].lo[2:0]);
                K_IRQ: cmp_bits(irq_req, q[0].lo[2:0]);
                K_OUT: cmp_bits({1'b0, compare_out_b, compare_out_a}, q[0].lo[2:0]);
                default: cmp_bits({2'h0, bottom}, q[0].lo[2:0]);
            endcase
            void'(q.pop_front());
        end
        if (cyc > 30000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // drivers: change after an edge; strobes last one cycle
    // ------------------------------------------------------------------
    task automatic step(int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic set_ctrl(logic [2:0] wgm, logic [2:0] cs, logic [1:0] com, logic [2:0] msk,
                            logic pd);
        @(posedge mclk);
        t0 = cyc;
        ctrl <= '{wgm, cs, com, com};
        timer_mask_reg <= msk;
        timer_power_down_bit <= pd;
    endtask

    task automatic strobe(int s, logic [7:0] v);
        @(posedge mclk);
        t0 = cyc;
        timer_count_wdata <= v;
        compare_wdata <= v;
        flag_wdata <= v[2:0];
        case (s)
            S_CNT: timer_count_we <= 1'b1;
            S_CA: compare_a_we <= 1'b1;
            S_CB: compare_b_we <= 1'b1;
            S_FLG: flag_we <= 1'b1;
            S_ACK: irq_ack <= v[2:0];
            default: force_compare_bit <= v[1:0];
        endcase
        @(posedge mclk);
        {timer_count_we, compare_a_we, compare_b_we, flag_we} <= 4'h0;
        irq_ack <= 3'h0;
        force_compare_bit <= 2'h0;
    endtask

    task automatic pin(logic b);
        @(posedge mclk);
        ext_count_pin <= b;
        step(3);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {mclk, timer_power_down_bit, timer_count_we, compare_a_we, compare_b_we} = 5'h0;
        {flag_we, ext_count_pin, force_compare_bit, timer_mask_reg, flag_wdata, irq_ack} = 13'h0;
        {timer_count_wdata, compare_wdata, ctrl} = 26'h0;
        {cyc, fails, comparisons} = 0;
        seed = 37;
        rst = 1'b1;
        step(4);
        rst <= 1'b0;
        t0 = cyc;
        note(K_CNT, 8'h00, 1);
        note(K_FLG, 8'h00, 1);
        note(K_OUT, 8'h00, 1);
        note(K_BOT, 8'h01, 1);
        $display("test reset done");
        repeat (4) begin
            r = $random(seed) & 32'hFFFFFF7F; // no 0xFF left to overflow
            strobe(S_CNT, r[7:0]);
            note(K_CNT, r[7:0], 1);
            note(K_CNT, r[7:0], 4);
            strobe(S_CA, r[15:8]);
            note(K_CVA, r[15:8], 1);
            strobe(S_CB, r[23:16]);
            note(K_CVB, r[23:16], 1);
        end
        $display("test access done");
        strobe(S_CA, 8'h10);
        strobe(S_CB, 8'h12);
        set_ctrl(3'h0, 3'h1, 2'h0, 3'h7, 1'b0);
        strobe(S_CNT, 8'hFE);
        note(K_CNT, 8'hFE, 1);
        note(K_BOT, 8'h00, 2);
        note(K_FLG, 8'h00, 2);
        note(K_CNT, 8'h00, 3);
        note(K_FLG, 8'h01, 3);
        note(K_IRQ, 8'h01, 3);
        step(4);
        set_ctrl(3'h0, 3'h0, 2'h0, 3'h5, 1'b0);
        strobe(S_FLG, 8'h07);
        note(K_FLG, 8'h00, 1);
        set_ctrl(3'h0, 3'h1, 2'h0, 3'h5, 1'b0);
        strobe(S_CNT, 8'h0E);
        note(K_FLG, 8'h00, 3);
        note(K_FLG, 8'h02, 4);
        note(K_IRQ, 8'h00, 4);
        note(K_FLG, 8'h06, 6);
        note(K_IRQ, 8'h04, 6);
        step(8);
        set_ctrl(3'h0, 3'h0, 2'h0, 3'h5, 1'b0);
        strobe(S_FLG, 8'h02);
        note(K_FLG, 8'h04, 1);
        strobe(S_ACK, 8'h04);
        note(K_FLG, 8'h00, 1);
        $display("test flags done");
        for (int i = 0; i < 7; i++) begin
            set_ctrl(3'h0, 3'h0, 2'h0, 3'h0, 1'b0);
            strobe(S_CNT, 8'h00);
            set_ctrl(3'h0, 3'(i + 1), 2'h0, 3'h0, 1'b0);
            if (i < 5) begin
                note(K_CNT, 8'h03, 4 * FAC[i], 4);
                step(4 * FAC[i]);
            end else begin
                repeat (3) begin
                    pin(1'b1);
                    pin(1'b0);
                end
                set_ctrl(3'h0, 3'h0, 2'h0, 3'h0, 1'b0);
                note(K_CNT, 8'h03, 2);
            end
        end
        $display("test clock select done");
        set_ctrl(3'h0, 3'h1, 2'h0, 3'h0, 1'b1);
        strobe(S_CNT, 8'h20);
        note(K_CNT, 8'h20, 1);
        note(K_CNT, 8'h20, 6);
        step(6);
        set_ctrl(3'h0, 3'h1, 2'h0, 3'h0, 1'b0);
        note(K_CNT, 8'h21, 4, 8'h24);
        step(4);
        set_ctrl(3'h0, 3'h0, 2'h0, 3'h0, 1'b0);
        strobe(S_FLG, 8'h07);
        $display("test power down done");
        for (int i = 0; i < 5; i++) begin
            set_ctrl(3'h0, 3'h0, COM_SEQ[i], 3'h7, 1'b0);
            strobe(S_FRC, 8'h03);
            note(K_OUT, 8'(OUT_EXP[i]), 1);
            note(K_FLG, 8'h00, 1);
        end
        $display("test force done");
        set_ctrl(3'h3, 3'h0, 2'h0, 3'h0, 1'b0);
        strobe(S_CA, 8'h33);
        note(K_CVA, 8'h33, 1);
        set_ctrl(3'h3, 3'h1, 2'h0, 3'h0, 1'b0);
        strobe(S_CNT, 8'h30);
        note(K_FLG, 8'h00, 200);
        note(K_FLG, 8'h05, 240);
        note(K_FLG, 8'h07, 262);
        step(264);
        $display("test buffering done");
        set_ctrl(3'h2, 3'h0, 2'h0, 3'h0, 1'b0);
        strobe(S_CA, 8'h05);
        set_ctrl(3'h2, 3'h1, 2'h0, 3'h0, 1'b0);
        strobe(S_CNT, 8'h00);
        note(K_CNT, 8'h05, 6);
        note(K_CNT, 8'h00, 7);
        note(K_CNT, 8'h01, 8);
        step(10);
        $display("test clear on compare done");
        conclude();
    end
endmodule

bind tmz_timer tmz_timer_chk u_chk (.mclk, .rst, .ctrl, .timer_power_down_bit, .timer_mask_reg,
    .timer_count_we, .timer_count_wdata, .compare_a_we, .compare_wdata, .force_compare_bit,
    .flag_we, .flag_wdata, .irq_ack, .timer_count, .compare_value_a, .timer_flag_reg,
    .irq_req, .bottom);
